// ==== irq_defs.svh ====
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// register offsets (byte addresses as printed)
`define IRQ_CTRL_OFFSET 16'h1010
`define IRQ_STAT_OFFSET 16'h1020
// field positions inside the control register
`define IRQ_ENABLE_LSB 0
`define IRQ_MASK_LSB 8
`define IRQ_EDGE_BIT 14
`define IRQ_GATE_BIT 15
// reset values
`define IRQ_CTRL_RESET 16'h0000
`define IRQ_STAT_RESET 8'h00
// channel count
`define IRQ_CHANNELS 6
// low time of the request pulse in edge mode, in clock cycles
`define IRQ_PULSE_CYCLES 4'h1

`endif

// ==== irq_pkg.sv ====
package irq_pkg;
	// one bit per event source, bit order fixed by the channel numbers
	typedef struct packed {
		logic dma_done;     // 5
		logic rtc_event;    // 4
		logic bch_error;    // 3
		logic count_over;   // 2
		logic protect_viol; // 1
		logic flash_ready;  // 0
	} irq_src_s;

	// host register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef enum logic [1:0] {
		OUT_IDLE = 2'b00,
		OUT_PULSE = 2'b01,
		OUT_HOLD = 2'b10
	} out_state_e;
endpackage : irq_pkg

// ==== irq_regread.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"
// read multiplexer with registered data; keeps the read path off the top module
module irq_regread (
	input wire logic REF_CLK,           // system clock
	input wire logic RST_N,             // synchronous reset, active low
	input wire logic CE,                // clock enable
	input wire logic rd,                // read strobe
	input wire logic [15:0] addr,       // read address
	input wire logic [15:0] ctrl_val,   // control register contents
	input wire logic [5:0] stat_val,    // status bits
	output logic [15:0] rdata           // read data, one cycle later
);
	logic [15:0] rdata_reg; // registered answer
	logic [15:0] rdata_next; // answer being formed

	// decode; unmapped addresses answer zero
	always_comb begin
		rdata_next = rdata_reg;
		if (rd) begin
			unique case (addr)
				`IRQ_CTRL_OFFSET: rdata_next = ctrl_val;
				`IRQ_STAT_OFFSET: rdata_next = {10'h000, stat_val};
				default: rdata_next = 16'h0000;
			endcase
		end
	end

	// answer holds until the next read
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			rdata_reg <= 16'h0000;
		end else if (CE) begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;
endmodule : irq_regread
`default_nettype wire

// ==== irq_unit.sv ====
// How it works
// - six event channels, numbered zero to five
// - enable bit lets status latch source activity
// - enable low holds status bit cleared
// - mask one lets status assert request
// - mask zero blocks that channel's request
// - level mode holds request until cleared
// - edge mode pulses request low once
// - gate on permits request, fires pending
// - gate off forces request high
// - status register shows one bit per channel
// - both registers reset to zero
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"
module irq_unit (
	input wire logic REF_CLK,                 // 100 MHz system clock
	input wire logic RST_N,                   // synchronous reset, active low
	input wire logic CE,                      // clock enable, freezes all state when low
	input wire irq_pkg::irq_src_s SRC,        // event sources, same clock, high = activity
	input wire logic [15:0] ADDR,             // register address
	input wire logic [15:0] WDATA,            // register write data
	input wire logic WR,                      // write strobe
	input wire logic RD,                      // read strobe
	output logic [15:0] RDATA,                // read data, cycle after the read strobe
	output logic IRQ_N                        // interrupt request, active low
);
	import irq_pkg::*;

	// whole state of this module
	typedef struct packed {
		logic [5:0] enable;   // per channel enable
		logic [5:0] mask;     // per channel routing
		logic edge_mode;      // trigger select
		logic gate;           // global request gate
		logic [5:0] status;   // latched activity
		logic [5:0] seen;     // pending conditions already signalled in edge mode
		out_state_e ost;      // request output state
		logic [3:0] pcnt;     // pulse length counter
		logic irq_n;          // registered request pin
	} state_s;

	state_s st_reg; // current state
	state_s st_next; // next state
	logic [15:0] ctrl_val; // control register image
	logic [5:0] active; // pending and routed channels
	logic [5:0] fresh; // routed pending not yet pulsed
	logic wr_ctrl; // write to control register
	logic wr_stat; // write to status register

	// control register image with reserved bits as zero
	function automatic logic [15:0] ctrl_image(input state_s s);
		ctrl_image = {s.gate, s.edge_mode, s.mask, 2'b00, s.enable};
	endfunction : ctrl_image

	assign wr_ctrl = WR && (ADDR == `IRQ_CTRL_OFFSET);
	assign wr_stat = WR && (ADDR == `IRQ_STAT_OFFSET);
	assign ctrl_val = ctrl_image(st_reg);
	assign active = st_reg.status & st_reg.mask;
	assign fresh = active & ~st_reg.seen;

	// next state: register writes, status latching, output sequencing
	always_comb begin
		st_next = st_reg;
		// control fields; bits 7-6 dropped on write
		if (wr_ctrl) begin
			st_next.enable = WDATA[`IRQ_ENABLE_LSB +: 6];
			st_next.mask = WDATA[`IRQ_MASK_LSB +: 6];
			st_next.edge_mode = WDATA[`IRQ_EDGE_BIT];
			st_next.gate = WDATA[`IRQ_GATE_BIT];
		end
		// status is sticky; a host write may only clear bits, and a source event in
		// the same cycle wins over that clear
		if (wr_stat) begin
			st_next.status = st_reg.status & WDATA[5:0];
		end
		// sources share our clock, so they are latched straight away without a synchroniser
		st_next.status = st_next.status | (SRC & st_reg.enable);
		// disabled channels are held clear; enable off then on re-arms
		st_next.status = st_next.status & st_next.enable;
		// signalled marks follow the status so a re-armed channel may pulse again
		st_next.seen = st_reg.seen & st_next.status;
		st_next.irq_n = 1'b1;
		unique case (st_reg.ost)
			OUT_IDLE: begin
				if (st_reg.gate && st_reg.edge_mode && fresh != 6'h00) begin
					st_next.ost = OUT_PULSE;
					st_next.pcnt = `IRQ_PULSE_CYCLES;
					st_next.seen = (st_reg.seen | active) & st_next.status;
					st_next.irq_n = 1'b0;
				end else if (st_reg.gate && !st_reg.edge_mode && active != 6'h00) begin
					st_next.ost = OUT_HOLD;
					st_next.irq_n = 1'b0;
				end
			end
			OUT_PULSE: begin
				// pulse is one fixed length, then back high
				if (st_reg.pcnt > 4'h1) begin
					st_next.pcnt = st_reg.pcnt - 4'h1;
					st_next.irq_n = st_reg.gate ? 1'b0 : 1'b1;
				end else begin
					st_next.pcnt = 4'h0;
				end
				if (!st_reg.gate || st_reg.pcnt <= 4'h1) begin
					st_next.ost = OUT_IDLE;
				end
			end
			OUT_HOLD: begin
				// held while anything routed is pending
				if (st_reg.gate && !st_reg.edge_mode && active != 6'h00) begin
					st_next.irq_n = 1'b0;
				end else begin
					st_next.ost = OUT_IDLE;
				end
			end
			default: begin
				st_next.ost = OUT_IDLE;
			end
		endcase
		// in level mode nothing counts as signalled, so a switch to edge pulses
		if (!st_reg.edge_mode) begin
			st_next.seen = 6'h00;
		end
	end

	// one register for all state
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			st_reg.enable <= 6'h00;
			st_reg.mask <= 6'h00;
			st_reg.edge_mode <= 1'b0;
			st_reg.gate <= 1'b0;
			st_reg.status <= 6'h00;
			st_reg.seen <= 6'h00;
			st_reg.ost <= OUT_IDLE;
			st_reg.pcnt <= 4'h0;
			st_reg.irq_n <= 1'b1;
		end else if (CE) begin
			st_reg <= st_next;
		end
	end

	assign IRQ_N = st_reg.irq_n;

	// read port, registered
	irq_regread u_read (
		.REF_CLK(REF_CLK),
		.RST_N(RST_N),
		.CE(CE),
		.rd(RD),
		.addr(ADDR),
		.ctrl_val(ctrl_val),
		.stat_val(st_reg.status),
		.rdata(RDATA)
	);

	// checks
	// all of them run on the one system clock and are quiet during reset,
	// except the reset check itself, which must look at the reset cycle.
	// most antecedents carry CE, since a frozen cycle keeps every flop as it was
	// and the expected change then simply has not happened yet.
	// hazards watched here:
	// - a status write in the same cycle as a level request can drop the pin
	//   one cycle early, which is allowed, so the hold check excludes it
	// - a switch from level to edge mode may start a fresh pulse at once,
	//   so the pulse check looks at the pulse state, not at the mode alone
	// - the pulse count is fixed at one cycle; a longer count would need
	//   the pulse checks widened to the new length
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// reset leaves control, status and pin in their idle values
	a_reset_clear: assert property (disable iff (1'b0) !RST_N
		|=> ctrl_val == `IRQ_CTRL_RESET && st_reg.status == 6'h00 && IRQ_N)
		else $error("reset values wrong");

	// gate off drives the pin high on the next cycle
	a_gate_off_high: assert property (CE && !st_reg.gate |=> IRQ_N)
		else $error("request asserted with gate off");
	// gate off also sends the output machine home
	a_gate_idle: assert property (CE && !st_reg.gate
		|=> st_reg.ost == OUT_IDLE)
		else $error("output state busy with gate off");

	// a disabled channel keeps its status clear
	a_disabled_clear: assert property (CE && !st_next.enable[0] |=> !st_reg.status[0])
		else $error("disabled channel status not clear");
	// an event on a disabled channel never reaches the status
	a_disabled_event: assert property (CE && !st_reg.enable[2] && !wr_ctrl && !st_reg.status[2]
		|=> !st_reg.status[2])
		else $error("disabled channel latched an event");
	// clearing the whole enable field empties the status at once
	a_enable_clears: assert property (CE && wr_ctrl && WDATA[5:0] == 6'h00
		|=> st_reg.status == 6'h00)
		else $error("status kept after enable cleared");

	// an enabled event is latched on the next edge
	a_latch_event: assert property (CE && st_reg.enable[1] && SRC[1] && !wr_ctrl |=> st_reg.status[1])
		else $error("enabled event not latched");

	// level request stays low while routed status stands
	a_level_hold: assert property (CE && st_reg.gate && !st_reg.edge_mode && active != 6'h00 && !wr_ctrl
		&& !wr_stat ##1 CE |=> !IRQ_N)
		else $error("level request not held");
	// a held request lets go once nothing routed is pending
	a_level_release: assert property (CE && st_reg.ost == OUT_HOLD && active == 6'h00
		|=> IRQ_N)
		else $error("level request held without cause");

	// nothing routed and idle means the pin stays high
	a_mask_block: assert property (CE && active == 6'h00 && st_reg.ost == OUT_IDLE |=> IRQ_N)
		else $error("request without routed status");
	// all masks shut keeps the pin high once idle
	a_no_route_high: assert property (CE && st_reg.mask == 6'h00 && st_reg.ost == OUT_IDLE
		|=> IRQ_N)
		else $error("request with every mask shut");

	// an edge pulse is one cycle low
	a_edge_pulse: assert property (CE && st_reg.ost == OUT_PULSE && !IRQ_N |=> IRQ_N)
		else $error("edge pulse too long");
	// the pulse state never lasts two cycles
	a_pulse_state: assert property (CE && st_reg.ost == OUT_PULSE
		|=> st_reg.ost != OUT_PULSE)
		else $error("pulse state stuck");
	// in edge mode a pulse needs a newly pending channel
	a_edge_cause: assert property (CE && st_reg.edge_mode && fresh == 6'h00 && st_reg.ost != OUT_HOLD
		|=> IRQ_N)
		else $error("edge pulse without new cause");
	// signalled marks only stand on pending channels
	a_seen_subset: assert property ((st_reg.seen & ~st_reg.status) == 6'h00)
		else $error("signalled mark without status");

	// opening the gate on pending routed status fires the request
	a_gate_fires: assert property (CE && st_reg.gate && !st_reg.edge_mode && active != 6'h00
		&& st_reg.ost == OUT_IDLE |=> !IRQ_N)
		else $error("pending not fired on gate");

	// reserved bits of the control image read as zero
	a_reserved_zero: assert property (ctrl_val[7:6] == 2'b00)
		else $error("reserved control bits nonzero");
	// a control write lands whole, minus the reserved bits
	a_ctrl_write: assert property (CE && wr_ctrl
		|=> ctrl_val == {$past(WDATA[15:8]), 2'b00, $past(WDATA[5:0])})
		else $error("control write not applied");
	// control read returns the image of the read cycle
	a_ctrl_read: assert property (RD && CE && ADDR == `IRQ_CTRL_OFFSET
		|=> RDATA == $past(ctrl_val))
		else $error("control read mismatch");
	// unmapped reads answer zero
	a_unmapped_zero: assert property (RD && CE && ADDR != `IRQ_CTRL_OFFSET && ADDR != `IRQ_STAT_OFFSET
		|=> RDATA == 16'h0000)
		else $error("unmapped read not zero");

	// status read returns one bit per channel, upper bits zero
	a_status_read: assert property (RD && CE && ADDR == `IRQ_STAT_OFFSET |=> RDATA == {10'h000, $past(st_reg.status)})
		else $error("status read mismatch");
	// read data hold until the next read
	a_read_hold: assert property (CE && !RD
		|=> RDATA == $past(RDATA))
		else $error("read data changed without a read");

	// main scenarios worth seeing at least once
	c_level_irq: cover property (!st_reg.edge_mode && !IRQ_N);
	c_edge_irq: cover property (st_reg.edge_mode && !IRQ_N);
	c_rearm: cover property (st_reg.status[0] ##1 !st_reg.enable[0] ##1 st_reg.enable[0]);
	// gate opened on something already pending
	c_gate_open: cover property (!st_reg.gate ##1 st_reg.gate && active != 6'h00);
endmodule : irq_unit
`default_nettype wire

// ==== irq_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side of the request line: counts cycles spent low since the last clear
module irq_host_model (
	input wire logic clk,     // system clock
	input wire logic irq_n,   // request line from the unit
	input wire logic clr,     // restart the count
	output int low_cycles     // cycles seen with the line low
);
	// sampled on the clock, as a synchronous host would see the line
	always @(posedge clk) begin
		if (clr) begin
			low_cycles <= 0;
		end else if (irq_n === 1'b0) begin
			low_cycles <= low_cycles + 1;
		end
	end
endmodule : irq_host_model
`default_nettype wire

// ==== test_flash_disk_interrupt_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_flash_disk_interrupt_unit;
	import irq_pkg::*;
	logic REF_CLK = 0; // 100 MHz
	logic RST_N = 0; // held low for 8 cycles
	logic CE = 1; // always running
	logic [5:0] src = 0; // event sources
	logic [15:0] ADDR = 0, WDATA = 0, RDATA;
	logic WR = 0, RD = 0, IRQ_N, rd_pend = 0, clr = 0;
	int low_cycles, error_cnt = 0, num_checks = 0, cyc = 0;
	logic [15:0] exp_q[$]; // expected read data, oldest first
	always #5 REF_CLK = ~REF_CLK;
	irq_unit irq_unit_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .SRC(irq_src_s'(src)), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_N(IRQ_N));
	irq_host_model irq_host_model_inst (.clk(REF_CLK), .irq_n(IRQ_N), .clr(clr), .low_cycles(low_cycles));
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task conclude;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	// one-cycle write strobe
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge REF_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1;
		@(posedge REF_CLK);
		WR <= 0;
	endtask : wr
	// read strobe; the monitor compares one cycle later
	task rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge REF_CLK);
		ADDR <= a;
		RD <= 1;
		exp_q.push_back(e);
		@(posedge REF_CLK);
		RD <= 0;
	endtask : rd
	// one-cycle burst of source activity
	task pulse(input logic [5:0] v);
		@(posedge REF_CLK);
		src <= v;
		@(posedge REF_CLK);
		src <= 0;
	endtask : pulse
	// request line checked mid-cycle, after the answer latency has run out
	task chk_irq(input logic e);
		repeat (3) @(negedge REF_CLK);
		chk("irq_n", {15'h0, e}, {15'h0, IRQ_N});
	endtask : chk_irq
	// read data monitor: pops the oldest note whenever a read was taken
	always @(posedge REF_CLK) rd_pend <= RD & CE;
	always @(negedge REF_CLK) begin
		if (rd_pend) begin
			chk("rdata", exp_q.pop_front(), RDATA);
		end
	end
	// hang guard, well above the roughly 160 cycles needed
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		logic [5:0] rnd;
		void'($urandom(32'h1e5a));
		repeat (8) @(posedge REF_CLK);
		RST_N <= 1;
		rd(16'h1010, 16'h0000);
		rd(16'h1020, 16'h0000);
		chk_irq(1);
		// each channel alone, random noise on the disabled ones
		for (int ch = 0; ch < 6; ch++) begin
			rnd = 6'($urandom());
			wr(16'h1010, 16'h8000 | (16'h0101 << ch));
			pulse((6'h01 << ch) | rnd);
			rd(16'h1020, 16'h0001 << ch);
			chk_irq(0);
			wr(16'h1010, 16'h8000 | (16'h0100 << ch));
			chk_irq(1);
			wr(16'h1010, 16'h8000 | (16'h0101 << ch));
			chk_irq(1);
			rd(16'h1020, 16'h0000);
		end
		// all pending with masks shut, then the global gate
		wr(16'h1010, 16'h003F);
		pulse(6'h3F);
		rd(16'h1020, 16'h003F);
		chk_irq(1);
		wr(16'h1010, 16'h3F3F);
		chk_irq(1);
		wr(16'h1010, 16'hBF3F);
		chk_irq(0);
		wr(16'h1010, 16'hBF00);
		chk_irq(1);
		wr(16'h1010, 16'hFFFF);
		rd(16'h1010, 16'hFF3F);
		rd(16'h1030, 16'h0000);
		// edge mode: exactly one low cycle per new event
		wr(16'h1010, 16'h0000);
		wr(16'h1010, 16'hC101);
		clr <= 1;
		@(posedge REF_CLK);
		clr <= 0;
		pulse(6'h01);
		repeat (8) @(negedge REF_CLK);
		chk("pulse_len", 16'h0001, 16'(low_cycles));
		conclude();
	end
endmodule : test_flash_disk_interrupt_unit
`default_nettype wire
